// ==== common/sws_pkg.sv ====
// Constants and carrier types for the selective wake SPI control block.
// Assumes a 100 MHz core clock and a host-driven SPI link sampled by that clock.
// Requirements of the document
// RQ1: Command executes within 6 us of chip select going high.
// RQ2: Host leaves 3 us between commands and keeps chip select high long enough.
// RQ3: Serial input is sampled at falling clock edges; host sets mode accordingly.
// RQ4: Each status-information bit is set when any bit of its register is set; the selective wake bit uses only its pattern and frame flags.
// RQ5: An 8-bit scratch register is written only by the host.
// RQ6: Wake, failure and diagnosis flags hold until the host clears them.
// RQ7: Selective wake registers exist only on variants with partial networking.
// RQ8: Config-valid flag clears on any selective wake change or config error.
// RQ9: After arming, status must show armed 1, sync 1, pattern 0, frame 0.
// RQ10: Any wake event disables the selective wake function.
// RQ11: Host checks and clears wake status before commanding sleep.
// RQ12: Host runs low-power entry right after enabling selective wake.
// RQ13: Host programs the frame length code equal to configured data bytes.
// RQ14: The identifier mask cannot mask the identifier-extension bit.
// RQ15: Host fills wake data bytes from the highest data register downward.
// RQ16: Host fills identifier registers from the highest register downward.
// RQ17: Host enables clock recovery with settings chosen for its baud rate.
// RQ18: Tolerance setting only for mixed networks at 500 kBit/s and 2 MBit/s.
// RQ19: Read-to-clear thermal prewarning flag, reset 0, set near critical temperature.
// RQ20: Read-to-clear supply undervoltage prewarning flag, reset 0, set below threshold.
// RQ21: Host returns to the normal receiver after leaving partial networking.
// RQ22: Control registers accept configuration while in normal mode.
// RQ23: A prewarning flag clears on read and sets again if still present.
`default_nettype none
package sws_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int EXEC_MAX_NS = 6000;
   localparam int EXEC_MAX_CYC = EXEC_MAX_NS / CLK_PERIOD_NS;
   localparam int FRAME_BITS = 16;
   localparam logic [6:0] ADDR_SCRATCH = 7'h00;
   localparam logic [6:0] ADDR_MODE = 7'h01;
   localparam logic [6:0] ADDR_SWK_BASE = 7'h10;
   localparam int SWK_N = 23;
   localparam int SWK_CTRL_IDX = 0;
   localparam int SWK_ID_IDX = 5;
   localparam int SWK_MASK_IDX = 9;
   localparam int SWK_DLC_IDX = 13;
   localparam int SWK_DATA_IDX = 14;
   localparam int SWK_FD_IDX = 22;
   localparam logic [6:0] ADDR_WAKE_ST = 7'h30;
   localparam logic [6:0] ADDR_FAIL_ST = 7'h31;
   localparam logic [6:0] ADDR_DIAG_ST = 7'h32;
   localparam logic [6:0] ADDR_SWK_ST = 7'h33;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CFG_BIT = 5;
   localparam int DIAG_TPW_BIT = 0;
   localparam int DIAG_UV_BIT = 1;
   localparam int ST_ARMED_BIT = 0;
   localparam int ST_SYNC_BIT = 1;
   localparam int ST_WUP_BIT = 2;
   localparam int ST_WUF_BIT = 3;
   localparam logic [7:0] SCRATCH_RST = 8'h00;
   localparam logic [7:0] REG_RST = 8'h00;
   typedef enum logic [1:0] {SWS_NORMAL, SWS_STOP, SWS_SLEEP} sws_mode_t;
   typedef struct packed {
      logic enable;
      logic wake_rx_sel;
      logic cdr_en;
      logic fd_en;
      logic ide;
      logic [31:0] id;
      logic [31:0] id_mask;
      logic [3:0] dlc;
      logic [63:0] data;
      logic [31:0] recovery;
      logic [7:0] fd_tolerance_control;
   } sws_swk_cfg_t;
   typedef struct packed {
      logic sync_ok;
      logic wake_pattern_seen;
      logic wake_frame_seen;
      logic config_error;
   } sws_ph_evt_t;
endpackage
`default_nettype wire

// ==== sim/sws_host_model.sv ====
// Behavioural SPI master standing in for the host microcontroller.
// Assumes the device samples data at falling clock edges and shifts output at rising ones.
`default_nettype none
module sws_host_model
   import sws_pkg::*;
(
   input wire logic clk,
   output logic chip_select_line_n,
   output logic spi_clk,
   output logic spi_mosi,
   input wire logic spi_miso
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      chip_select_line_n = 1'b1;
      spi_clk = 1'b0;
      spi_mosi = 1'b0;
   end

   // Runs one frame of nbits bits, MSB first; rx collects what is seen at each fall.
   // The 300 cycle wait keeps 3 us between frames and puts every edge just after a clk rise.
   task automatic xfer(input logic [15:0] frame, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      repeat (300) @(posedge clk);
      #1 chip_select_line_n = 1'b0;
      #80;
      for (int i = 0; i < nbits; i++) begin
         spi_mosi = frame[15 - i];
         #40 spi_clk = 1'b1;
         #40 spi_clk = 1'b0;
         rx = {rx[14:0], spi_miso};
      end
      #80 chip_select_line_n = 1'b1;
      // A released data line must not keep showing its last bit.
      spi_mosi = ~spi_mosi;
   endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the selective wake SPI control block.
// Assumes the host model for SPI frames and a second instance built without partial networking.
`default_nettype none
module tb_top
   import sws_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, resetn, cs_n, sclk, mosi, miso_a, miso_b, pick_b, therm, uv;
   logic [7:0] wake_src, fail_src;
   sws_ph_evt_t ph_evt;
   sws_swk_cfg_t swk_cfg;
   sws_mode_t mode;
   int n_fail = 0;
   int total_checks = 0;

   sws_spi_ctrl #(.HAS_PN(1'b1)) DUT (.clk(clk), .resetn(resetn), .chip_select_line_n(cs_n),
      .spi_clk(sclk), .spi_mosi(mosi), .spi_miso_o(miso_a), .spi_miso_oe(),
      .wake_src(wake_src), .fail_src(fail_src), .thermal_near_limit(therm),
      .main_supply_below_warn(uv), .ph_evt(ph_evt), .swk_cfg(swk_cfg), .mode(mode));
   sws_spi_ctrl #(.HAS_PN(1'b0)) dut_nopn (.clk(clk), .resetn(resetn), .chip_select_line_n(cs_n),
      .spi_clk(sclk), .spi_mosi(mosi), .spi_miso_o(miso_b), .spi_miso_oe(),
      .wake_src(wake_src), .fail_src(fail_src), .thermal_near_limit(therm),
      .main_supply_below_warn(uv), .ph_evt(ph_evt), .swk_cfg(), .mode());
   sws_host_model host (.clk(clk), .chip_select_line_n(cs_n), .spi_clk(sclk), .spi_mosi(mosi),
      .spi_miso(pick_b ? miso_b : miso_a));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] rx;
      host.xfer({1'b1, a, d}, 16, rx);
   endtask

   task automatic rd(input logic [6:0] a, output logic [15:0] rx);
      host.xfer({1'b0, a, 8'h00}, 16, rx);
   endtask

   // Lets a command run to completion within the longest allowed execution time.
   task automatic settle();
      repeat (EXEC_MAX_CYC) @(posedge clk);
      #1;
   endtask

   task automatic arm();
      wr(ADDR_SWK_BASE + 7'(SWK_CTRL_IDX), 8'h3F);
      settle();
      chk({7'h00, swk_cfg.enable}, 8'h01);
   endtask

   task automatic wrap_up();
      if (n_fail == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #400000;
      n_fail++;
      wrap_up();
   end

   initial begin
      logic [15:0] rx;
      int n;
      resetn = 1'b0;
      pick_b = 1'b0;
      therm = 1'b0;
      uv = 1'b0;
      wake_src = 8'h00;
      fail_src = 8'h00;
      ph_evt = '0;
      repeat (20) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (5) @(posedge clk);
      rd(ADDR_SCRATCH, rx);
      chk(rx[7:0], SCRATCH_RST);
      rd(ADDR_DIAG_ST, rx);
      chk(rx[7:0], 8'h00);
      wr(ADDR_SCRATCH, 8'hA5);
      rd(ADDR_SCRATCH, rx);
      chk(rx[7:0], 8'hA5);
      host.xfer({1'b1, ADDR_SCRATCH, 8'h3C}, 15, rx);
      rd(ADDR_SCRATCH, rx);
      chk(rx[7:0], 8'hA5);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) #1;
         if (k == 0) wake_src = 8'h04;
         else fail_src = 8'h81;
         @(posedge clk) #1;
         wake_src = 8'h00;
         fail_src = 8'h00;
         rd(ADDR_WAKE_ST + 7'(k), rx);
         rd(ADDR_WAKE_ST + 7'(k), rx);
         chk(rx[7:0], k == 0 ? 8'h04 : 8'h81);
         chk(rx[15:8], 8'h01 << k);
         wr(ADDR_WAKE_ST + 7'(k), rx[7:0]);
         rd(ADDR_WAKE_ST + 7'(k), rx);
         chk(rx[7:0], 8'h00);
      end
      @(posedge clk) #1 therm = 1'b1;
      @(posedge clk) #1 therm = 1'b0;
      rd(ADDR_DIAG_ST, rx);
      chk(rx[7:0], 8'h01);
      chk(rx[15:8], 8'h04);
      rd(ADDR_DIAG_ST, rx);
      chk(rx[7:0], 8'h00);
      uv = 1'b1;
      rd(ADDR_DIAG_ST, rx);
      chk(rx[7:0], 8'h02);
      rd(ADDR_DIAG_ST, rx);
      settle();
      uv = 1'b0;
      chk(rx[7:0], 8'h02);
      rd(ADDR_DIAG_ST, rx);
      chk(rx[7:0], 8'h02);
      rd(ADDR_DIAG_ST, rx);
      chk(rx[7:0], 8'h00);
      wr(ADDR_SWK_BASE + 7'(SWK_ID_IDX + 3), 8'h12);
      wr(ADDR_SWK_BASE + 7'(SWK_ID_IDX + 2), 8'h34);
      wr(ADDR_SWK_BASE + 7'(SWK_DATA_IDX + 7), 8'hC3);
      wr(ADDR_SWK_BASE + 7'(SWK_DATA_IDX + 6), 8'h5A);
      wr(ADDR_SWK_BASE + 7'(SWK_DLC_IDX), 8'h02);
      wr(ADDR_SWK_BASE + 7'h01, 8'h96);
      wr(ADDR_SWK_BASE + 7'(SWK_MASK_IDX + 3), 8'h7F);
      wr(ADDR_SWK_BASE + 7'(SWK_FD_IDX), 8'h4B);
      arm();
      chk({7'h00, swk_cfg.ide}, 8'h01);
      chk(swk_cfg.id_mask[31:24], 8'h7F);
      chk(swk_cfg.recovery[7:0], 8'h96);
      chk({7'h00, swk_cfg.fd_en}, 8'h01);
      chk(swk_cfg.fd_tolerance_control, 8'h4B);
      chk({7'h00, swk_cfg.wake_rx_sel}, 8'h01);
      chk(swk_cfg.id[31:24], 8'h12);
      chk(swk_cfg.id[23:16], 8'h34);
      chk(swk_cfg.data[63:56], 8'hC3);
      chk(swk_cfg.data[55:48], 8'h5A);
      chk({4'h0, swk_cfg.dlc}, 8'h02);
      chk({7'h00, swk_cfg.cdr_en}, 8'h01);
      ph_evt.sync_ok = 1'b1;
      rd(ADDR_SWK_ST, rx);
      chk(rx[7:0], 8'h03);
      wr(ADDR_SWK_BASE + 7'(SWK_DLC_IDX), 8'h02);
      settle();
      chk({7'h00, swk_cfg.enable}, 8'h00);
      arm();
      @(posedge clk) #1 ph_evt.config_error = 1'b1;
      @(posedge clk) #1 ph_evt.config_error = 1'b0;
      chk({7'h00, swk_cfg.enable}, 8'h00);
      arm();
      @(posedge clk) #1 wake_src = 8'h01;
      @(posedge clk) #1 wake_src = 8'h00;
      chk({7'h00, swk_cfg.enable}, 8'h00);
      pick_b = 1'b1;
      rd(ADDR_SWK_BASE + 7'(SWK_ID_IDX + 3), rx);
      chk(rx[7:0], 8'h00);
      pick_b = 1'b0;
      rd(ADDR_SWK_BASE + 7'(SWK_ID_IDX + 3), rx);
      chk(rx[7:0], 8'h12);
      @(posedge clk) #1 ph_evt.wake_frame_seen = 1'b1;
      @(posedge clk) #1 ph_evt.wake_frame_seen = 1'b0;
      rd(ADDR_SWK_ST, rx);
      chk(rx[7:0], 8'h0A);
      chk(rx[15:8], 8'h09);
      wr(ADDR_SWK_ST, 8'h08);
      rd(ADDR_SWK_ST, rx);
      chk(rx[7:0], 8'h02);
      rd(ADDR_WAKE_ST, rx);
      wr(ADDR_WAKE_ST, rx[7:0]);
      rd(ADDR_WAKE_ST, rx);
      chk(rx[7:0], 8'h00);
      wr(ADDR_MODE, {6'h00, SWS_SLEEP});
      n = 0;
      while (mode !== SWS_SLEEP && n < EXEC_MAX_CYC) begin
         @(posedge clk) #1;
         n++;
      end
      chk({6'h00, mode}, {6'h00, SWS_SLEEP});
      wr(ADDR_SCRATCH, 8'h11);
      rd(ADDR_SCRATCH, rx);
      chk(rx[7:0], 8'hA5);
      wr(ADDR_MODE, {6'h00, SWS_NORMAL});
      settle();
      chk({6'h00, mode}, {6'h00, SWS_NORMAL});
      wr(ADDR_SWK_BASE + 7'(SWK_CTRL_IDX), 8'h00);
      settle();
      chk({7'h00, swk_cfg.wake_rx_sel}, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire

// ==== verilog/sws_spi_ctrl.sv ====
// SPI register port and selective wake control of the system basis chip.
// Assumes the host is SPI master; its clock, select and data are asynchronous pins.
`default_nettype none
module sws_spi_ctrl
   import sws_pkg::*;
#(
   parameter bit HAS_PN = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic chip_select_line_n,
   input wire logic spi_clk,
   input wire logic spi_mosi,
   output logic spi_miso_o,
   output logic spi_miso_oe,
   input wire logic [7:0] wake_src,
   input wire logic [7:0] fail_src,
   input wire logic thermal_near_limit,
   input wire logic main_supply_below_warn,
   input wire sws_ph_evt_t ph_evt,
   output sws_swk_cfg_t swk_cfg,
   output sws_mode_t mode
);
   logic [2:0] cs_s_r, ck_s_r, di_s_r;
   logic cs_q_r, ck_q_r, di_q_r;
   logic cs_fall, cs_rise, ck_fall, ck_rise;
   logic [4:0] bitcnt_r;
   logic [15:0] rx_r;
   logic [7:0] tx_r;
   logic exec;
   logic is_wr;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] scratch_r;
   logic [7:0] swk_r [SWK_N];
   logic swk_en_r, cfg_valid_r;
   logic [7:0] wake_st_r, fail_st_r, diag_st_r, swk_st_r;
   logic [3:0] status_info;
   logic [7:0] rd_data;
   logic swk_hit, wake_evt;
   logic [6:0] swk_idx;
   logic [6:0] rx_addr;

   // Pins pass three flops; a level is accepted once the second and third agree.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs_s_r <= 3'h7;
         ck_s_r <= 3'h0;
         di_s_r <= 3'h0;
      end else begin
         cs_s_r <= {cs_s_r[1:0], chip_select_line_n};
         ck_s_r <= {ck_s_r[1:0], spi_clk};
         di_s_r <= {di_s_r[1:0], spi_mosi};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs_q_r <= 1'b1;
         ck_q_r <= 1'b0;
         di_q_r <= 1'b0;
      end else begin
         if (cs_s_r[1] == cs_s_r[2]) cs_q_r <= cs_s_r[2];
         if (ck_s_r[1] == ck_s_r[2]) ck_q_r <= ck_s_r[2];
         if (di_s_r[1] == di_s_r[2]) di_q_r <= di_s_r[2];
      end
   end

   assign cs_fall = cs_q_r && (cs_s_r[1] == cs_s_r[2]) && !cs_s_r[2];
   assign cs_rise = !cs_q_r && (cs_s_r[1] == cs_s_r[2]) && cs_s_r[2];
   assign ck_fall = !cs_q_r && ck_q_r && (ck_s_r[1] == ck_s_r[2]) && !ck_s_r[2];
   assign ck_rise = !cs_q_r && !ck_q_r && (ck_s_r[1] == ck_s_r[2]) && ck_s_r[2];

   // Receive on falling edges, shift the answer out on rising edges, MSB first.
   // The first rise keeps the preloaded bit, so the host reads every bit at a falling edge.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bitcnt_r <= 5'h00;
         rx_r <= 16'h0000;
         tx_r <= 8'h00;
      end else if (cs_fall) begin
         bitcnt_r <= 5'h00;
         tx_r <= {4'h0, status_info};
      end else if (ck_fall && bitcnt_r < 5'(FRAME_BITS)) begin
         rx_r <= {rx_r[14:0], di_q_r}; // RQ3
         bitcnt_r <= bitcnt_r + 5'h01;
      end else if (ck_rise && bitcnt_r != 5'h00) begin
         tx_r <= (bitcnt_r == 5'h08) ? rd_data : {tx_r[6:0], 1'b0};
      end
   end

   assign spi_miso_o = tx_r[7];
   assign spi_miso_oe = !cs_q_r;

   // Only complete frames run, in the cycle chip select is seen high.
   assign exec = cs_rise && (bitcnt_r == 5'(FRAME_BITS)); // RQ1
   assign is_wr = rx_r[15];
   assign addr = rx_r[14:8];
   assign wdata = rx_r[7:0];
   // After the first eight bits the address byte sits in the low bits of the shift register.
   assign rx_addr = (bitcnt_r == 5'h08) ? rx_r[6:0] : addr;
   assign swk_idx = rx_addr - ADDR_SWK_BASE;
   assign swk_hit = HAS_PN && rx_addr >= ADDR_SWK_BASE
                    && rx_addr < ADDR_SWK_BASE + 7'(SWK_N); // RQ7
   assign wake_evt = (|wake_src) || ph_evt.wake_frame_seen || ph_evt.wake_pattern_seen;

   assign status_info = {|swk_st_r[ST_WUF_BIT:ST_WUP_BIT], |diag_st_r,
                         |fail_st_r, |wake_st_r}; // RQ4

   always_comb begin
      rd_data = 8'h00;
      if (rx_addr == ADDR_SCRATCH) rd_data = scratch_r;
      else if (rx_addr == ADDR_MODE) rd_data = {6'h00, mode};
      else if (rx_addr == ADDR_WAKE_ST) rd_data = wake_st_r;
      else if (rx_addr == ADDR_FAIL_ST) rd_data = fail_st_r;
      else if (rx_addr == ADDR_DIAG_ST) rd_data = diag_st_r;
      else if (rx_addr == ADDR_SWK_ST && HAS_PN) rd_data = swk_st_r;
      else if (swk_hit && swk_idx == 7'(SWK_CTRL_IDX))
         rd_data = {2'h0, cfg_valid_r, swk_r[SWK_CTRL_IDX][4:1], swk_en_r};
      else if (swk_hit) rd_data = swk_r[swk_idx[4:0]];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) mode <= SWS_NORMAL;
      else if (exec && is_wr && addr == ADDR_MODE) begin
         case (wdata[1:0])
            2'h1: mode <= SWS_STOP;
            2'h2: mode <= SWS_SLEEP;
            default: mode <= SWS_NORMAL;
         endcase
      end
   end

   // The scratch byte changes only by a host write in normal mode.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) scratch_r <= SCRATCH_RST;
      else if (exec && is_wr && addr == ADDR_SCRATCH && mode == SWS_NORMAL)
         scratch_r <= wdata; // RQ5 RQ22
   end

   genvar gi;
   generate
      for (gi = 0; gi < SWK_N; gi++) begin : g_swk
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) swk_r[gi] <= REG_RST;
            else if (exec && is_wr && swk_hit && swk_idx == 7'(gi) && mode == SWS_NORMAL)
               swk_r[gi] <= wdata; // RQ22
         end
      end
   endgenerate

   // A wake event overrides a host enable in the same cycle.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) swk_en_r <= 1'b0;
      else if (!HAS_PN || wake_evt) swk_en_r <= 1'b0; // RQ10 RQ7
      else if (exec && is_wr && swk_hit && swk_idx == 7'(SWK_CTRL_IDX) && mode == SWS_NORMAL)
         swk_en_r <= wdata[CTRL_EN_BIT];
   end

   // Any selective wake write drops validity unless it sets the valid bit itself.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) cfg_valid_r <= 1'b0;
      else if (ph_evt.config_error) cfg_valid_r <= 1'b0; // RQ8
      else if (exec && is_wr && swk_hit && mode == SWS_NORMAL)
         cfg_valid_r <= swk_idx == 7'(SWK_CTRL_IDX) && wdata[CTRL_CFG_BIT]; // RQ8
   end

   // Sticky flags: write 1 to clear, and a new event in the same cycle wins.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wake_st_r <= REG_RST;
         fail_st_r <= REG_RST;
      end else begin
         wake_st_r <= (wake_st_r & ~((exec && is_wr && addr == ADDR_WAKE_ST) ? wdata : 8'h00))
                      | wake_src; // RQ6
         fail_st_r <= (fail_st_r & ~((exec && is_wr && addr == ADDR_FAIL_ST) ? wdata : 8'h00))
                      | fail_src; // RQ6
      end
   end

   // Prewarnings clear when read and set again while the condition lasts.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) diag_st_r <= REG_RST;
      else begin
         diag_st_r <= (diag_st_r & ~((exec && !is_wr && addr == ADDR_DIAG_ST) ? 8'hFF : 8'h00))
                      | {6'h00, main_supply_below_warn, thermal_near_limit}; // RQ19 RQ20 RQ23
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) swk_st_r <= REG_RST;
      else if (!HAS_PN) swk_st_r <= REG_RST; // RQ7
      else begin
         swk_st_r[ST_ARMED_BIT] <= swk_en_r && cfg_valid_r; // RQ9
         swk_st_r[ST_SYNC_BIT] <= ph_evt.sync_ok; // RQ9
         swk_st_r[ST_WUP_BIT] <= ph_evt.wake_pattern_seen || (swk_st_r[ST_WUP_BIT]
            && !(exec && is_wr && addr == ADDR_SWK_ST && wdata[ST_WUP_BIT]));
         swk_st_r[ST_WUF_BIT] <= ph_evt.wake_frame_seen || (swk_st_r[ST_WUF_BIT]
            && !(exec && is_wr && addr == ADDR_SWK_ST && wdata[ST_WUF_BIT]));
         swk_st_r[7:4] <= 4'h0;
      end
   end

   // The identifier-extension bit comes from the control byte and has no mask bit.
   always_comb begin
      swk_cfg.enable = swk_en_r && cfg_valid_r;
      swk_cfg.wake_rx_sel = swk_r[SWK_CTRL_IDX][1];
      swk_cfg.cdr_en = swk_r[SWK_CTRL_IDX][2];
      swk_cfg.fd_en = swk_r[SWK_CTRL_IDX][3];
      swk_cfg.ide = swk_r[SWK_CTRL_IDX][4]; // RQ14
      swk_cfg.id = {swk_r[SWK_ID_IDX+3], swk_r[SWK_ID_IDX+2], swk_r[SWK_ID_IDX+1], swk_r[SWK_ID_IDX]};
      swk_cfg.id_mask = {swk_r[SWK_MASK_IDX+3], swk_r[SWK_MASK_IDX+2],
                         swk_r[SWK_MASK_IDX+1], swk_r[SWK_MASK_IDX]};
      swk_cfg.dlc = swk_r[SWK_DLC_IDX][3:0];
      swk_cfg.data = {swk_r[SWK_DATA_IDX+7], swk_r[SWK_DATA_IDX+6], swk_r[SWK_DATA_IDX+5],
                      swk_r[SWK_DATA_IDX+4], swk_r[SWK_DATA_IDX+3], swk_r[SWK_DATA_IDX+2],
                      swk_r[SWK_DATA_IDX+1], swk_r[SWK_DATA_IDX]};
      swk_cfg.recovery = {swk_r[4], swk_r[3], swk_r[2], swk_r[1]};
      swk_cfg.fd_tolerance_control = swk_r[SWK_FD_IDX];
   end

   property p_exec_in_time;
      @(posedge clk) disable iff (!resetn)
      $rose(chip_select_line_n) && bitcnt_r == 5'(FRAME_BITS) |-> ##[1:6] exec ##1 !spi_miso_oe;
   endproperty
   a_exec_in_time: assert property (p_exec_in_time) else $error("command late"); // RQ1

   property p_fall_sample;
      @(posedge clk) disable iff (!resetn)
      ck_fall && bitcnt_r < 5'(FRAME_BITS) |=> rx_r[0] == $past(di_q_r);
   endproperty
   a_fall_sample: assert property (p_fall_sample) else $error("bit not sampled"); // RQ3

   property p_info_load;
      @(posedge clk) disable iff (!resetn)
      cs_fall && (|wake_st_r) |=> tx_r[0];
   endproperty
   a_info_load: assert property (p_info_load) else $error("info bit missing"); // RQ4

   property p_scratch_hold;
      @(posedge clk) disable iff (!resetn)
      !(exec && is_wr && addr == ADDR_SCRATCH && mode == SWS_NORMAL) |=> $stable(scratch_r);
   endproperty
   a_scratch_hold: assert property (p_scratch_hold) else $error("scratch changed"); // RQ5

   property p_wake_sticky;
      @(posedge clk) disable iff (!resetn)
      !(exec && is_wr && addr == ADDR_WAKE_ST) ##1 1'b1 |-> (wake_st_r & $past(wake_st_r)) == $past(wake_st_r);
   endproperty
   a_wake_sticky: assert property (p_wake_sticky) else $error("wake flag lost"); // RQ6

   property p_pn_absent;
      @(posedge clk) disable iff (!resetn)
      !HAS_PN |=> !swk_en_r && swk_st_r == 8'h00;
   endproperty
   a_pn_absent: assert property (p_pn_absent) else $error("swk present"); // RQ7

   property p_cfg_err;
      @(posedge clk) disable iff (!resetn)
      ph_evt.config_error |=> !cfg_valid_r ##1 !swk_st_r[ST_ARMED_BIT];
   endproperty
   a_cfg_err: assert property (p_cfg_err) else $error("valid kept"); // RQ8

   property p_wake_off;
      @(posedge clk) disable iff (!resetn)
      wake_evt |=> !swk_en_r ##1 !swk_cfg.enable;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("swk still on"); // RQ10

   property p_tpw_set;
      @(posedge clk) disable iff (!resetn)
      thermal_near_limit |=> diag_st_r[DIAG_TPW_BIT];
   endproperty
   a_tpw_set: assert property (p_tpw_set) else $error("prewarn missed"); // RQ19

   property p_rc_clear;
      @(posedge clk) disable iff (!resetn)
      exec && !is_wr && addr == ADDR_DIAG_ST && !main_supply_below_warn |=> !diag_st_r[DIAG_UV_BIT];
   endproperty
   a_rc_clear: assert property (p_rc_clear) else $error("no read clear"); // RQ20 RQ23

   c_write: cover property (@(posedge clk) disable iff (!resetn) exec && is_wr);
   c_diag_read: cover property (@(posedge clk) disable iff (!resetn)
      exec && !is_wr && addr == ADDR_DIAG_ST);
   c_armed_wake: cover property (@(posedge clk) disable iff (!resetn) swk_en_r && wake_evt);
endmodule
`default_nettype wire
